// >>> rtl/tune_pkg.sv
/*
 Constants, field encodings and carrier structs for the tuning session supervisor.
 Assumes one 250 MHz clock and a plain register port driven by a local master.
*/
// Operation
// - Auto-tune needs run, PID, auto, local
// - Limits: high >= 0.1 %, low <= 99.9 %
// - Measured value healthy and inside error points
// - Cancel restores the PID values from before
// - Stop, PID, manual, remote cancel auto-tune
// - Setpoint, bias, filter, ratio, area edits cancel
// - Scale fault or error point cancels
// - Auto-tune limited to two hours
// - Power loss over 20 ms cancels tuning
// - Instrument fault cancels auto-tune
// - Selector on starts; lamp flashes; done ends
// - Auto-tune may start in any phase
// - Tuning output values only with valve feedback
// - Start condition 0, 1, 2 selects triggers
// - No power-up tuning cooling or positioning
// - Power-on/run trigger forces warm restart 2; code gives none for a run trigger with a setpoint edit in the same cycle
// - Heat/cool power-up tuning stores heat side only
// - Run-once success clears method to disabled
// - Power-up tuning limited to hundred minutes
package tune_pkg;
    localparam int CLK_HZ = 250_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int AT_LIMIT_MIN = 120;
    localparam int ST_LIMIT_MIN = 100;
    localparam int AT_LIMIT_TICKS = AT_LIMIT_MIN * 60_000 / TICK_MS;
    localparam int ST_LIMIT_TICKS = ST_LIMIT_MIN * 60_000 / TICK_MS;
    localparam int PWR_FAIL_MS = 20;
    localparam int PWR_FAIL_CYCLES = CLK_HZ / 1000 * PWR_FAIL_MS;
    localparam int FLASH_TICKS = 500;
    // Output limits in tenths of a percent
    localparam logic [15:0] OUT_HI_MIN = 16'h0001;
    localparam logic [15:0] OUT_LO_MAX = 16'h03e7;
    localparam logic [15:0] OUT_HI_RESET = 16'h03e8;
    localparam logic [15:0] OUT_LO_RESET = 16'h0000;
    localparam logic [15:0] ERR_HI_RESET = 16'hffff;
    localparam logic [15:0] ERR_LO_RESET = 16'h0000;
    localparam int AW = 4;
    localparam logic [AW-1:0] A_CTRL = 4'h0;
    localparam logic [AW-1:0] A_METHOD = 4'h1;
    localparam logic [AW-1:0] A_STATUS = 4'h2;
    localparam logic [AW-1:0] A_OUT_HI = 4'h3;
    localparam logic [AW-1:0] A_OUT_LO = 4'h4;
    localparam logic [AW-1:0] A_ERR_HI = 4'h5;
    localparam logic [AW-1:0] A_ERR_LO = 4'h6;
    localparam logic [AW-1:0] A_COND = 4'h7;
    localparam logic [1:0] RUN_ONCE_CHOICE = 2'h1;
    localparam logic [1:0] RUN_EVERY_TIME_CHOICE = 2'h2;
    localparam logic [1:0] METHOD_DISABLED = 2'h0;
    localparam logic [1:0] COND_ALL = 2'h0;
    localparam logic [1:0] COND_POWER_RUN = 2'h1;
    localparam logic [1:0] COND_SETPOINT = 2'h2;
    // Control register bit positions
    localparam int C_RUN = 0;
    localparam int C_AT_SEL = 1;
    localparam int C_MANUAL = 2;
    localparam int C_REMOTE = 3;
    localparam int C_HEATCOOL = 4;
    localparam int C_POSPROP = 5;
    localparam int C_VALVE_FB = 6;
    localparam int C_FALLING = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    typedef struct packed {
        logic underscale;
        logic overscale;
        logic [15:0] value;
    } meas_s;

    typedef struct packed {
        logic setpoint;
        logic bias;
        logic filter;
        logic ratio;
        logic area;
    } edit_s;
endpackage

// >>> rtl/tick_divider.sv
/*
 Divider that produces a one-cycle enable every DIV cycles.
 Assumes a free-running clock and asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
    parameter int DIV = 250_000
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    output logic tick_out
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic tick_nxt;

    always_comb
    begin
        tick_nxt = (cnt_r == 32'(DIV - 1));
        cnt_nxt = tick_nxt ? 32'h0 : cnt_r + 32'h1;
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            cnt_r <= 32'h0;
            tick_out <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            tick_out <= tick_nxt;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/tuning_session_supervisor.sv
/*
 Supervisor for the auto-tune and power-up tuning sessions of a temperature controller.
 Assumes the PID engine reports completion and the measured value is sampled on clk_in.
 Power-good and fault arrive from pins and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module tuning_session_supervisor #(
    parameter int TICK_DIV = tune_pkg::TICK_CYCLES,
    parameter int AT_LIMIT = tune_pkg::AT_LIMIT_TICKS,
    parameter int ST_LIMIT = tune_pkg::ST_LIMIT_TICKS,
    parameter int PWR_FAIL = tune_pkg::PWR_FAIL_CYCLES
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire tune_pkg::reg_req_s req_in,
    output logic [15:0] rdata_out,
    input wire tune_pkg::meas_s meas_in,
    input wire tune_pkg::edit_s edit_in,
    input wire logic tune_done_in,
    input wire logic power_good_in,
    input wire logic fault_in,
    output logic lamp_out,
    output logic at_active_out,
    output logic st_active_out,
    output logic restore_pid_out,
    output logic store_heat_only_out,
    output logic warm_restart2_out,
    output logic tune_out_valid_out
);
    import tune_pkg::*;

    typedef enum logic [1:0] {IDLE, AUTO, POWERUP} sess_e;

    sess_e sess_r, sess_nxt;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [1:0] method_r, method_nxt;
    logic [1:0] cond_r, cond_nxt;
    logic [15:0] out_hi_r, out_hi_nxt, out_lo_r, out_lo_nxt;
    logic [15:0] err_hi_r, err_hi_nxt, err_lo_r, err_lo_nxt;
    logic [15:0] rdata_nxt;
    logic [31:0] tcnt_r, tcnt_nxt;
    logic [31:0] pcnt_r, pcnt_nxt;
    logic [9:0] fcnt_r, fcnt_nxt;
    logic flash_r, flash_nxt;
    logic pg_s1_r, pg_s2_r, flt_s1_r, flt_s2_r;
    logic boot_r, boot_nxt, run_d_r;
    logic last_cancel_r, last_cancel_nxt;
    logic restore_nxt, heat_only_nxt, warm2_nxt, outv_nxt, lamp_nxt;
    logic tick;
    logic modes_ok, limits_ok, meas_ok, any_edit, pwr_lost, cancel, st_trig, st_allowed;
    logic wr_ctrl_atsel_off;

    tick_divider #(
        .DIV(TICK_DIV)
    ) u_tick (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .tick_out(tick)
    );

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            pg_s1_r <= 1'b0;
            pg_s2_r <= 1'b0;
            flt_s1_r <= 1'b0;
            flt_s2_r <= 1'b0;
        end
        else
        begin
            pg_s1_r <= power_good_in;
            pg_s2_r <= pg_s1_r;
            flt_s1_r <= fault_in;
            flt_s2_r <= flt_s1_r;
        end
    end

    always_comb
    begin
        modes_ok = ctrl_r[C_RUN] && !ctrl_r[C_MANUAL] && !ctrl_r[C_REMOTE];
        limits_ok = (out_hi_r >= OUT_HI_MIN) && (out_lo_r <= OUT_LO_MAX);
        // measured value health; touching a point is an error
        meas_ok = !meas_in.underscale && !meas_in.overscale
            && (meas_in.value < err_hi_r) && (meas_in.value > err_lo_r);
        any_edit = |edit_in;
        // power loss longer than the limit
        pwr_lost = (pcnt_r >= 32'(PWR_FAIL));
        // no power-up tuning when cooling or positioning
        st_allowed = !ctrl_r[C_POSPROP] && !(ctrl_r[C_HEATCOOL] && ctrl_r[C_FALLING]);
        // trigger selection; only when not disabled
        st_trig = (method_r != METHOD_DISABLED) && (
            ((cond_r != COND_SETPOINT) && (boot_r || (ctrl_r[C_RUN] && !run_d_r)))
            || ((cond_r != COND_POWER_RUN) && edit_in.setpoint));
        wr_ctrl_atsel_off = req_in.wr && (req_in.addr == A_CTRL) && !req_in.wdata[C_AT_SEL];
    end

    always_comb
    begin
        sess_nxt = sess_r;
        tcnt_nxt = tcnt_r;
        restore_nxt = 1'b0;
        warm2_nxt = 1'b0;
        cancel = 1'b0;
        last_cancel_nxt = last_cancel_r;
        ctrl_nxt = ctrl_r;
        method_nxt = method_r;
        cond_nxt = cond_r;
        out_hi_nxt = out_hi_r;
        out_lo_nxt = out_lo_r;
        err_hi_nxt = err_hi_r;
        err_lo_nxt = err_lo_r;
        boot_nxt = boot_r && !tick;
        pcnt_nxt = pg_s2_r ? 32'h0 : (pwr_lost ? pcnt_r : pcnt_r + 32'h1);
        if (req_in.wr)
        begin
            unique case (req_in.addr)
                A_CTRL: ctrl_nxt = req_in.wdata[7:0];
                A_METHOD: method_nxt = req_in.wdata[1:0];
                A_OUT_HI: out_hi_nxt = req_in.wdata;
                A_OUT_LO: out_lo_nxt = req_in.wdata;
                A_ERR_HI: err_hi_nxt = req_in.wdata;
                A_ERR_LO: err_lo_nxt = req_in.wdata;
                A_COND: cond_nxt = req_in.wdata[1:0];
                default: ;
            endcase
        end
        // fixed-period tick advances the session timer
        if (tick && sess_r != IDLE)
            tcnt_nxt = tcnt_r + 32'h1;
        unique case (sess_r)
            IDLE:
            begin
                if (ctrl_r[C_AT_SEL] && modes_ok && limits_ok && meas_ok && !flt_s2_r
                    && !pwr_lost)
                begin
                    sess_nxt = AUTO;
                    tcnt_nxt = 32'h0;
                end
                else if (st_trig && st_allowed && modes_ok && limits_ok && meas_ok
                    && !flt_s2_r && !pwr_lost)
                begin
                    sess_nxt = POWERUP;
                    tcnt_nxt = 32'h0;
                    // power-on, or a run change with no setpoint edit in the same cycle, forces warm restart 2
                    warm2_nxt = !edit_in.setpoint || boot_r;
                end
            end
            AUTO:
            begin
                cancel = !modes_ok || !ctrl_r[C_AT_SEL] || wr_ctrl_atsel_off || any_edit
                    || !meas_ok || (tcnt_r >= 32'(AT_LIMIT)) || pwr_lost || flt_s2_r;
            end
            POWERUP:
            begin
                cancel = !modes_ok || ctrl_r[C_AT_SEL] || (method_r == METHOD_DISABLED)
                    || edit_in.bias || edit_in.filter || edit_in.ratio || !meas_ok
                    || (tcnt_r >= 32'(ST_LIMIT)) || pwr_lost || flt_s2_r;
            end
            default: sess_nxt = IDLE;
        endcase
        if (sess_r != IDLE && cancel)
        begin
            // restore previous PID values at once
            sess_nxt = IDLE;
            restore_nxt = 1'b1;
            last_cancel_nxt = 1'b1;
            // Selector drops so a cancelled auto-tune does not restart by itself
            if (sess_r == AUTO)
                ctrl_nxt[C_AT_SEL] = 1'b0;
        end
        else if (sess_r != IDLE && tune_done_in)
        begin
            sess_nxt = IDLE;
            last_cancel_nxt = 1'b0;
            if (sess_r == AUTO)
                ctrl_nxt[C_AT_SEL] = 1'b0;
            if (sess_r == POWERUP && method_r == RUN_ONCE_CHOICE)
                method_nxt = METHOD_DISABLED;
        end
        heat_only_nxt = (sess_nxt == POWERUP) && ctrl_r[C_HEATCOOL];
        // tuning output values only with valve feedback
        outv_nxt = (sess_nxt == AUTO) && ctrl_r[C_POSPROP] && ctrl_r[C_VALVE_FB];
        fcnt_nxt = fcnt_r;
        flash_nxt = flash_r;
        if (tick)
        begin
            fcnt_nxt = (fcnt_r == 10'(FLASH_TICKS - 1)) ? 10'h0 : fcnt_r + 10'h1;
            if (fcnt_r == 10'(FLASH_TICKS - 1))
                flash_nxt = !flash_r;
        end
        // Flash phase restarts with each auto-tune session
        if (sess_nxt != AUTO)
        begin
            fcnt_nxt = 10'h0;
            flash_nxt = 1'b0;
        end
        lamp_nxt = (sess_nxt == AUTO) && flash_nxt;
        rdata_nxt = 16'h0;
        if (req_in.rd)
        begin
            unique case (req_in.addr)
                A_CTRL: rdata_nxt = {8'h0, ctrl_r};
                A_METHOD: rdata_nxt = {14'h0, method_r};
                A_STATUS: rdata_nxt = {12'h0, last_cancel_r, flt_s2_r,
                    sess_r == POWERUP, sess_r == AUTO};
                A_OUT_HI: rdata_nxt = out_hi_r;
                A_OUT_LO: rdata_nxt = out_lo_r;
                A_ERR_HI: rdata_nxt = err_hi_r;
                A_ERR_LO: rdata_nxt = err_lo_r;
                A_COND: rdata_nxt = {14'h0, cond_r};
                default: rdata_nxt = 16'h0;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            sess_r <= IDLE;
            ctrl_r <= CTRL_RESET;
            method_r <= METHOD_DISABLED;
            cond_r <= COND_ALL;
            out_hi_r <= OUT_HI_RESET;
            out_lo_r <= OUT_LO_RESET;
            err_hi_r <= ERR_HI_RESET;
            err_lo_r <= ERR_LO_RESET;
            tcnt_r <= 32'h0;
            pcnt_r <= 32'h0;
            fcnt_r <= 10'h0;
            flash_r <= 1'b0;
            boot_r <= 1'b1;
            run_d_r <= 1'b0;
            last_cancel_r <= 1'b0;
            rdata_out <= 16'h0;
            lamp_out <= 1'b0;
            at_active_out <= 1'b0;
            st_active_out <= 1'b0;
            restore_pid_out <= 1'b0;
            store_heat_only_out <= 1'b0;
            warm_restart2_out <= 1'b0;
            tune_out_valid_out <= 1'b0;
        end
        else
        begin
            sess_r <= sess_nxt;
            ctrl_r <= ctrl_nxt;
            method_r <= method_nxt;
            cond_r <= cond_nxt;
            out_hi_r <= out_hi_nxt;
            out_lo_r <= out_lo_nxt;
            err_hi_r <= err_hi_nxt;
            err_lo_r <= err_lo_nxt;
            tcnt_r <= tcnt_nxt;
            pcnt_r <= pcnt_nxt;
            fcnt_r <= fcnt_nxt;
            flash_r <= flash_nxt;
            boot_r <= boot_nxt;
            run_d_r <= ctrl_r[C_RUN];
            last_cancel_r <= last_cancel_nxt;
            rdata_out <= rdata_nxt;
            lamp_out <= lamp_nxt;
            at_active_out <= (sess_nxt == AUTO);
            st_active_out <= (sess_nxt == POWERUP);
            restore_pid_out <= restore_nxt;
            store_heat_only_out <= heat_only_nxt;
            warm_restart2_out <= warm2_nxt;
            tune_out_valid_out <= outv_nxt;
        end
    end

    chk_cancel_restores: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (sess_r != IDLE && cancel) |=> restore_pid_out && !at_active_out && !st_active_out)
        else $error("cancel did not restore PID");
    chk_fault_cancels: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (sess_r == AUTO && flt_s2_r) |=> sess_r == IDLE)
        else $error("fault left auto-tune running");
    chk_limit_gate: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (sess_r == IDLE && !limits_ok) |=> sess_r == IDLE)
        else $error("tuning began with bad limits");
    chk_mode_gate: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (sess_r == IDLE && !modes_ok) |=> sess_r == IDLE)
        else $error("tuning began outside run auto local");
    chk_at_timeout: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (sess_r == AUTO && tcnt_r >= 32'(AT_LIMIT)) |=> sess_r == IDLE ##0 restore_pid_out)
        else $error("auto-tune outran its limit");
    chk_once_clears: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (sess_r == POWERUP && !cancel && tune_done_in && method_r == RUN_ONCE_CHOICE)
        |=> method_r == METHOD_DISABLED)
        else $error("run-once method not cleared");
    chk_lamp_at: assert property (@(posedge clk_in) disable iff (!resetn_in)
        lamp_out |-> at_active_out)
        else $error("lamp lit outside auto-tune");
    chk_st_blocked: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (sess_r == IDLE && ctrl_r[C_POSPROP] && !ctrl_r[C_AT_SEL]) |=> sess_r == IDLE)
        else $error("power-up tuning in positioning control");
endmodule
`default_nettype wire

// >>> testbench/process_side_model.sv
/*
 Model of the keypad, host edits and process measurement facing the supervisor.
 Assumes the bench calls its tasks; every change lands just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module process_side_model (
    input wire logic clk_in,
    output var tune_pkg::meas_s meas_out,
    output var tune_pkg::edit_s edit_out,
    output var logic done_out,
    output var logic power_good_out,
    output var logic fault_out
);
    import tune_pkg::*;

    // wide gap: value held well inside the error points in use
    initial
    begin
        meas_out = '{underscale: 1'b0, overscale: 1'b0, value: 16'h0400};
        edit_out = '0;
        done_out = 1'b0;
        power_good_out = 1'b1;
        fault_out = 1'b0;
    end

    task automatic set_meas(input logic us, input logic os, input logic [15:0] v);
        @(posedge clk_in);
        meas_out <= '{underscale: us, overscale: os, value: v};
    endtask

    task automatic pulse_edit(input edit_s e);
        @(posedge clk_in);
        edit_out <= e;
        @(posedge clk_in);
        edit_out <= '0;
    endtask

    task automatic pulse_done();
        @(posedge clk_in);
        done_out <= 1'b1;
        @(posedge clk_in);
        done_out <= 1'b0;
    endtask

    // Supply dips shorter than the limit must pass unnoticed
    task automatic power_drop(input int n);
        @(posedge clk_in);
        power_good_out <= 1'b0;
        repeat (n) @(posedge clk_in);
        power_good_out <= 1'b1;
    endtask

    task automatic set_fault(input logic f);
        @(posedge clk_in);
        fault_out <= f;
    endtask
endmodule
`default_nettype wire

// >>> testbench/tuning_session_supervisor_bench.sv
/*
 Self-checking bench for the tuning session supervisor.
 Assumes shortened tick and limit parameters; far side is the process side model.
*/
`timescale 1ns/1ps
`default_nettype none
module tuning_session_supervisor_bench;
    import tune_pkg::*;
    localparam int TDIV = 10;
    localparam int ATL = 1200;
    localparam int STL = 20;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    reg_req_s req_in = '0;
    meas_s meas_in;
    edit_s edit_in;
    logic tune_done_in, power_good_in, fault_in;
    logic [15:0] rdata_out;
    logic lamp_out, at_active_out, st_active_out, restore_pid_out;
    logic store_heat_only_out, warm_restart2_out, tune_out_valid_out;
    int n_fail = 0;
    int check_count = 0;
    int n_restore = 0;
    int n_warm = 0;
    int t, r0, w0;
    logic [15:0] rv;
    logic [15:0] rst_val[9] = '{16'h0000, 16'h0000, 16'h0000, 16'h03e8, 16'h0000,
        16'hffff, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] sc[13] = '{16'h0184, 16'h018c, 16'h0194, 16'h0198, 16'h01ac, 16'h01a0,
        16'h0100, 16'h11ac, 16'h91a8, 16'h21a8, 16'h0154, 16'h016d, 16'h01ae};

    always #2 clk_in = ~clk_in;

    always @(posedge clk_in)
    begin
        if (restore_pid_out === 1'b1)
            n_restore <= n_restore + 1;
        if (warm_restart2_out === 1'b1)
            n_warm <= n_warm + 1;
    end

    process_side_model u_process_side_model (.clk_in(clk_in), .meas_out(meas_in),
        .edit_out(edit_in), .done_out(tune_done_in), .power_good_out(power_good_in),
        .fault_out(fault_in));

    tuning_session_supervisor #(.TICK_DIV(TDIV), .AT_LIMIT(ATL), .ST_LIMIT(STL),
        .PWR_FAIL(50)) u_tuning_session_supervisor (.clk_in(clk_in),
        .resetn_in(resetn_in), .req_in(req_in), .rdata_out(rdata_out), .meas_in(meas_in),
        .edit_in(edit_in), .tune_done_in(tune_done_in), .power_good_in(power_good_in),
        .fault_in(fault_in), .lamp_out(lamp_out), .at_active_out(at_active_out),
        .st_active_out(st_active_out), .restore_pid_out(restore_pid_out),
        .store_heat_only_out(store_heat_only_out), .warm_restart2_out(warm_restart2_out),
        .tune_out_valid_out(tune_out_valid_out));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            $display("BAD %s expected %h seen %h", what, exp, seen);
            n_fail++;
        end
    endtask

    function automatic logic sig(input int sel);
        case (sel)
            0: return at_active_out;
            1: return st_active_out;
            default: return lamp_out;
        endcase
    endfunction

    task automatic wait_sig(input int sel, input logic want, input int bound, output int took);
        took = 0;
        while (sig(sel) !== want && took < bound)
        begin
            @(posedge clk_in);
            #1;
            took++;
        end
        if (sig(sel) !== want)
        begin
            $display("BAD wait on %0d expected %b", sel, want);
            n_fail++;
            report_and_stop();
        end
    endtask

    task automatic wr_reg(input logic [AW-1:0] a, input logic [15:0] d);
        @(posedge clk_in);
        req_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        req_in <= '0;
    endtask

    task automatic rd_reg(input logic [AW-1:0] a, output logic [15:0] d);
        @(posedge clk_in);
        req_in <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        req_in <= '0;
        #1;
        d = rdata_out;
    endtask

    task automatic try_start(input logic [15:0] c, input logic e);
        wr_reg(A_CTRL, 16'h0001);
        wr_reg(A_CTRL, c);
        repeat (10) @(posedge clk_in);
        #1;
        check("start", {15'h0000, at_active_out}, {15'h0000, e});
    endtask

    task automatic start_at(input logic [15:0] c);
        wr_reg(A_CTRL, 16'h0001);
        wr_reg(A_CTRL, c);
        wait_sig(0, 1'b1, 20, t);
        repeat (2) @(posedge clk_in);
        #1;
    endtask

    initial
    begin
        logic [15:0] lim_d[4] = '{16'h0000, 16'h0001, 16'h03e8, 16'h03e7};
        logic [15:0] mv[6] = '{16'h0800, 16'h07ff, 16'h0100, 16'h0101, 16'h0400, 16'h0400};
        logic [15:0] cc[3] = '{16'h0007, 16'h000b, 16'h0002};
        repeat (10) @(posedge clk_in);
        resetn_in <= 1'b1;
        #1;
        check("outputs", {9'h000, lamp_out, at_active_out, st_active_out, restore_pid_out,
            store_heat_only_out, warm_restart2_out, tune_out_valid_out}, 16'h0000);
        for (int i = 0; i < 9; i++)
        begin
            rd_reg(i[3:0], rv);
            check("reset value", rv, rst_val[i]);
        end
        wr_reg(A_ERR_HI, 16'h0800);
        wr_reg(A_ERR_LO, 16'h0100);
        for (int k = 0; k < 4; k++)
        begin
            wr_reg((k < 2) ? A_OUT_HI : A_OUT_LO, lim_d[k]);
            try_start(16'h0003, k[0]);
        end
        for (int k = 0; k < 6; k++)
        begin
            u_process_side_model.set_meas(k == 4, k == 5, mv[k]);
            try_start(16'h0003, k < 4 && k[0]);
        end
        u_process_side_model.set_meas(1'b0, 1'b0, 16'h0400);
        for (int k = 0; k < 3; k++)
            try_start(cc[k], 1'b0);
        start_at(16'h0003);
        rd_reg(A_STATUS, rv);
        check("status active", rv & 16'h0001, 16'h0001);
        wait_sig(2, 1'b1, 5200, t);
        check("flash time", 16'(t > 4900 && t < 5050), 16'h0001);
        u_process_side_model.pulse_done();
        wait_sig(0, 1'b0, 30, t);
        repeat (2) @(posedge clk_in);
        #1;
        check("lamp off", {15'h0000, lamp_out}, 16'h0000);
        rd_reg(A_CTRL, rv);
        check("selector cleared", rv, 16'h0001);
        start_at(16'h0003);
        u_process_side_model.power_drop(30);
        repeat (5) @(posedge clk_in);
        #1;
        check("short dip", {15'h0000, at_active_out}, 16'h0001);
        for (int k = 0; k < 16; k++)
        begin
            start_at(16'h0003);
            r0 = n_restore;
            case (k)
                0: wr_reg(A_CTRL, 16'h0002);
                1: wr_reg(A_CTRL, 16'h0001);
                2: wr_reg(A_CTRL, 16'h0007);
                3: wr_reg(A_CTRL, 16'h000b);
                4, 5, 6, 7, 8: u_process_side_model.pulse_edit(edit_s'(5'h10 >> (k - 4)));
                9, 10: u_process_side_model.set_meas(k == 9, k == 10, 16'h0400);
                11: u_process_side_model.set_meas(1'b0, 1'b0, 16'h0800);
                12: u_process_side_model.set_meas(1'b0, 1'b0, 16'h0100);
                13: u_process_side_model.set_fault(1'b1);
                14: u_process_side_model.power_drop(70);
                default: ;
            endcase
            wait_sig(0, 1'b0, (k == 15) ? ATL * TDIV + 100 : 200, t);
            check("cancelled", {15'h0000, at_active_out}, 16'h0000);
            repeat (2) @(posedge clk_in);
            check("restore pulse", 16'(n_restore - r0 > 0), 16'h0001);
            if (k == 15)
                check("limit", 16'(t > ATL * TDIV - 60 && t < ATL * TDIV + 40), 16'h0001);
            u_process_side_model.set_meas(1'b0, 1'b0, 16'h0400);
            u_process_side_model.set_fault(1'b0);
        end
        start_at(16'h0023);
        check("tuning outputs", {15'h0000, tune_out_valid_out}, 16'h0000);
        start_at(16'h0063);
        check("tuning outputs", {15'h0000, tune_out_valid_out}, 16'h0001);
        for (int k = 0; k < 13; k++)
        begin
            wr_reg(A_CTRL, 16'h0000);
            wr_reg(A_METHOD, 16'h0000);
            wr_reg(A_COND, {14'h0000, sc[k][5:4]});
            if (sc[k][3])
                wr_reg(A_CTRL, {8'h00, sc[k][15:8]});
            wr_reg(A_METHOD, {14'h0000, sc[k][7:6]});
            w0 = n_warm;
            if (sc[k][3])
                u_process_side_model.pulse_edit(edit_s'(5'h10));
            else
                wr_reg(A_CTRL, {8'h00, sc[k][15:8]});
            if (sc[k][2])
                wait_sig(1, 1'b1, 30, t);
            else
                repeat (20) @(posedge clk_in);
            repeat (2) @(posedge clk_in);
            #1;
            check("st active", {15'h0000, st_active_out}, {15'h0000, sc[k][2]});
            check("warm restart", 16'(n_warm - w0), {15'h0000, sc[k][2] & ~sc[k][3]});
            check("heat only", {15'h0000, store_heat_only_out}, {15'h0000, sc[k][2] & sc[k][12]});
            r0 = n_restore;
            if (sc[k][2])
            begin
                case (sc[k][1:0])
                    2'h0: u_process_side_model.pulse_done();
                    2'h1: wr_reg(A_CTRL, 16'h0005);
                    default: ;
                endcase
                wait_sig(1, 1'b0, 400, t);
                repeat (2) @(posedge clk_in);
                check("st restore", 16'(n_restore - r0 > 0), {15'h0000, sc[k][1:0] != 2'h0});
                if (sc[k][1:0] == 2'h2)
                    check("st limit", 16'(t > 160 && t < 215), 16'h0001);
            end
            rd_reg(A_METHOD, rv);
            check("method", rv, (sc[k][7:6] == 2'h1 && sc[k][1:0] == 2'h0) ? 16'h0000
                : {14'h0000, sc[k][7:6]});
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
